// [dv/core_seq_model.sv]
/*
 * Behavioural model of the core's instruction sequencer as seen by the interrupt logic.
 * Assumes one clock and a synchronous active-high reset shared with the controller.
 */
`default_nettype none
module core_seq_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // pacing choice
  input wire logic slow_i,
  // to controller
  output logic instr_end_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // instruction pacing
  // ----------------------------------------------------------------
  logic [2:0] len_reg;
  // slow mode ends an instruction every fifth cycle so service must wait for it
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      len_reg <= 3'h0;
      instr_end_o <= 1'b0;
    end else begin
      len_reg <= (len_reg == 3'h4) ? 3'h0 : len_reg + 3'h1;
      instr_end_o <= slow_i ? (len_reg == 3'h4) : 1'b1;
    end
  end
endmodule // core_seq_model
`default_nettype wire

// [dv/vectored_fixed_priority_irq_tb.sv]
/*
 * Self-checking bench for the fixed-priority vectored interrupt controller.
 * Assumes the sequencer model in core_seq_model and the package constants.
 */
`default_nettype none
module vectored_fixed_priority_irq_tb;
  import irq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  sfr_bus_t sfr = '0;
  logic [14:0] ev = '0;
  logic ser_sel = 1'b0, f_set = 1'b0, f_clr = 1'b0, halt = 1'b0, slow = 1'b0;
  logic [7:0] rd;
  svc_t svc;
  logic dis, phi, osc, ie, ie_q;
  logic [15:0] q[$];
  int err_total = 0, n_checks = 0, phi_cnt = 0, a, b;
  initial forever #2 mclk_i = ~mclk_i;
  core_seq_model i_core (.mclk_i(mclk_i), .srst_i(srst_i), .slow_i(slow), .instr_end_o(ie));
  vectored_fixed_priority_irq #(.PHI_DIV(8'h02)) i_dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .sfr_i(sfr), .rd_data_o(rd),
    .ext_irq_in_a_i(~ev[0]), .ext_irq_in_b_i(~ev[1]), .ext_irq_in_c_i(~ev[10]),
    .ext_irq_in_d_i(~ev[11]), .ext_irq_in_e_i(~ev[12]), .ext_irq_in_f_i(~ev[13]),
    .serial_rx_irq_i(ev[2]), .serial_tx_irq_i(ev[3]), .serial_sel_i(ser_sel),
    .timer_x_irq_i(ev[4]), .timer_y_irq_i(ev[5]), .timer1_uflow_i(ev[6]),
    .timer2_irq_i(ev[7]), .counter_pin_a_irq_i(ev[8]), .counter_pin_b_irq_i(ev[9]),
    .soft_break_trap_i(ev[14]), .instr_end_i(ie), .flag_set_i(f_set), .flag_clr_i(f_clr),
    .oscillator_halt_op_i(halt), .svc_o(svc), .irq_disable_o(dis), .phi_en_o(phi),
    .osc_run_o(osc));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk_i) sfr <= '{addr: ad, wdata: d, we: 1'b1};
    @(posedge mclk_i) sfr.we <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] ad, input logic [7:0] e);
    @(posedge mclk_i) sfr.addr <= ad;
    @(posedge mclk_i);
    #1 check("rd_data", {8'h00, e}, {8'h00, rd});
  endtask
  task automatic fire(input logic [14:0] m);
    @(posedge mclk_i) ev <= m;
    @(posedge mclk_i) ev <= '0;
  endtask
  task automatic pulse_flag(input logic set);
    @(posedge mclk_i) begin
      f_set <= set;
      f_clr <= ~set;
    end
    @(posedge mclk_i) begin
      f_set <= 1'b0;
      f_clr <= 1'b0;
    end
  endtask
  // bounded wait; running out counts as a mismatch and ends the run
  task automatic await_empty();
    for (int i = 0; i < 80 && q.size() > 0; i++) @(posedge mclk_i);
    if (q.size() > 0) begin
      err_total++;
      $display("wrong value service start expected pending seen none");
      wrap_up();
    end
  endtask
  task automatic phi_win(input int n);
    #1 phi_cnt = 0;
    tick(n);
  endtask
  function automatic logic [15:0] vec(input int i);
    return (i == 14) ? VEC_BREAK_LO : 16'(VEC_TOP_LO - VEC_STEP * 16'(i));
  endfunction
  // ----------------------------------------------------------------
  // output watcher: oldest note against each service start
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    ie_q <= ie;
    if (phi === 1'b1) phi_cnt++;
    if (svc.start === 1'b1) begin
      if (q.size() == 0) begin
        check("unexpected start", 16'h0000, 16'h0001);
      end else begin
        check("vec_lo", q[0], svc.vec_lo);
        check("vec_hi", q[0] + 16'h0001, svc.vec_hi);
        // reset is taken without an instruction boundary
        if (q[0] !== VEC_RESET_LO) check("instr_end", 16'h0001, {15'h0, ie_q});
        void'(q.pop_front());
      end
    end
  end
  initial begin
    tick(20000);
    err_total++;
    $display("wrong value run length expected finish seen hang");
    wrap_up();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hE52D));
    q.push_back(VEC_RESET_LO);
    tick(4);
    srst_i <= 1'b0;
    await_empty();
    check("irq_disable", 16'h0001, {15'h0, dis});
    rdchk(ADDR_EDGE_SEL, REG_RST_VAL);
    rdchk(ADDR_REQ1, REG_RST_VAL);
    rdchk(ADDR_REQ2, REG_RST_VAL);
    rdchk(ADDR_CTRL1, REG_RST_VAL);
    rdchk(ADDR_CTRL2, REG_RST_VAL);
    $display("test reset done");
    wr(ADDR_CTRL1, 8'hFF);
    wr(ADDR_CTRL2, 8'h3F);
    @(posedge mclk_i) ser_sel <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      slow <= i[0];
      pulse_flag(1'b0);
      q.push_back(vec(i));
      fire(15'h0001 << i);
      await_empty();
    end
    $display("test single sources done");
    // lower request must stay pending while disable is set by the first acceptance
    repeat (6) begin
      a = $urandom_range(13);
      b = (a + 1 + $urandom_range(12)) % 14;
      pulse_flag(1'b0);
      q.push_back(vec(a < b ? a : b));
      fire((15'h0001 << a) | (15'h0001 << b));
      await_empty();
      tick(8);
      pulse_flag(1'b0);
      q.push_back(vec(a < b ? b : a));
      await_empty();
    end
    $display("test simultaneous pairs done");
    fire(15'h0010);
    tick(10);
    rdchk(ADDR_REQ1, 8'h10);
    wr(ADDR_CTRL1, 8'hEF);
    pulse_flag(1'b0);
    tick(10);
    pulse_flag(1'b1);
    q.push_back(VEC_BREAK_LO);
    fire(15'h4000);
    await_empty();
    wr(ADDR_CTRL1, 8'hFF);
    tick(10);
    pulse_flag(1'b0);
    q.push_back(vec(4));
    await_empty();
    rdchk(ADDR_REQ1, 8'h00);
    $display("test masking done");
    fire(15'h0020);
    rdchk(ADDR_REQ1, 8'h20);
    wr(ADDR_REQ1, 8'h00);
    rdchk(ADDR_REQ1, 8'h00);
    // second request register through its own pending-write path
    fire(15'h0100);
    rdchk(ADDR_REQ2, 8'h01);
    wr(ADDR_REQ2, 8'h00);
    rdchk(ADDR_REQ2, 8'h00);
    pulse_flag(1'b0);
    tick(10);
    @(posedge mclk_i) ser_sel <= 1'b0;
    fire(15'h0004);
    tick(10);
    q.push_back(vec(2));
    @(posedge mclk_i) ser_sel <= 1'b1;
    await_empty();
    $display("test request write and serial gate done");
    pulse_flag(1'b0);
    wr(ADDR_EDGE_SEL, 8'h01);
    q.push_back(vec(0));
    @(posedge mclk_i) ev <= 15'h0001;
    tick(4);
    check("falling edge ignored", 16'h0001, 16'(q.size()));
    @(posedge mclk_i) ev <= '0;
    await_empty();
    wr(ADDR_EDGE_SEL, 8'h00);
    $display("test edge select done");
    @(posedge mclk_i) halt <= 1'b1;
    @(posedge mclk_i) halt <= 1'b0;
    phi_win(10);
    check("osc_run stopped", 16'h0000, {15'h0, osc});
    check("phi pulses stopped", 16'h0000, 16'(phi_cnt));
    fire(15'h0001);
    phi_win(10);
    check("osc_run woken", 16'h0001, {15'h0, osc});
    check("phi pulses waking", 16'h0000, 16'(phi_cnt));
    fire(15'h0040);
    phi_win(8);
    check("phi resumed", 16'h0001, {15'h0, phi_cnt > 0});
    $display("test stop mode done");
    wrap_up();
  end
endmodule // vectored_fixed_priority_irq_tb
`default_nettype wire

// [hw/irq_edge_detect.sv]
/*
 * Per-pin active-edge detector for the external interrupt inputs.
 * Assumes pins already synchronous to mclk_i; sel bit 1 picks the rising edge.
 */
`default_nettype none
module irq_edge_detect #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // pins and edge choice
  input wire logic [WIDTH-1:0] pin_i,
  input wire logic [WIDTH-1:0] rise_sel_i,
  // one-cycle events
  output logic [WIDTH-1:0] evt_o
);
  logic [WIDTH-1:0] prev_reg;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= pin_i;
    end
  end

  for (genvar g = 0; g < WIDTH; g++) begin : g_edge
    assign evt_o[g] = rise_sel_i[g] ? (pin_i[g] & ~prev_reg[g]) : (~pin_i[g] & prev_reg[g]);
  end
endmodule // irq_edge_detect
`default_nettype wire

// [hw/irq_pkg.sv]
/*
 * Shared constants and carriers for the vectored fixed-priority interrupt logic.
 * Assumes an 8-bit core that reaches the interrupt registers through its internal
 * special-function port and fetches vectors itself.
 */
`default_nettype none
package irq_pkg;
  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_EDGE_SEL = 8'h3A;
  localparam logic [7:0] ADDR_REQ1 = 8'h3C;
  localparam logic [7:0] ADDR_REQ2 = 8'h3D;
  localparam logic [7:0] ADDR_CTRL1 = 8'h3E;
  localparam logic [7:0] ADDR_CTRL2 = 8'h3F;
  localparam logic [7:0] REG_RST_VAL = 8'h00;
  localparam logic [7:0] REQ2_USED_MASK = 8'h3F;
  // ----------------------------------------------------------------
  // sources and vectors
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 15;
  localparam int NUM_EXT = 6;
  localparam logic [3:0] IDX_SER_RX = 4'h2;
  localparam logic [3:0] IDX_SER_TX = 4'h3;
  localparam logic [3:0] IDX_TIMER1 = 4'h6;
  localparam logic [3:0] IDX_BREAK = 4'hE;
  localparam logic [15:0] VEC_RESET_LO = 16'hFFFC;
  localparam logic [15:0] VEC_TOP_LO = 16'hFFFA;
  localparam logic [15:0] VEC_BREAK_LO = 16'hFFDC;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  localparam logic [7:0] PHI_DIV_DEF = 8'h02;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
  } sfr_bus_t;

  typedef struct packed {
    logic start;
    logic [15:0] vec_lo;
    logic [15:0] vec_hi;
  } svc_t;
endpackage : irq_pkg
`default_nettype wire

// [hw/vectored_fixed_priority_irq.sv]
/*
 * Fixed-priority vectored interrupt controller with stop-mode clock control.
 * Assumes the core pulses instr_end_i at instruction boundaries, fetches the
 * vector pair named on svc_o, and drives the disable-flag strobes.
 */
`default_nettype none
module vectored_fixed_priority_irq
  import irq_pkg::*;
#(
  parameter logic [7:0] PHI_DIV = PHI_DIV_DEF
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // core register port
  input wire sfr_bus_t sfr_i,
  output logic [7:0] rd_data_o,
  // external pins
  input wire logic ext_irq_in_a_i,
  input wire logic ext_irq_in_b_i,
  input wire logic ext_irq_in_c_i,
  input wire logic ext_irq_in_d_i,
  input wire logic ext_irq_in_e_i,
  input wire logic ext_irq_in_f_i,
  // internal peripheral events
  input wire logic serial_rx_irq_i,
  input wire logic serial_tx_irq_i,
  input wire logic serial_sel_i,
  input wire logic timer_x_irq_i,
  input wire logic timer_y_irq_i,
  input wire logic timer1_uflow_i,
  input wire logic timer2_irq_i,
  input wire logic counter_pin_a_irq_i,
  input wire logic counter_pin_b_irq_i,
  // core sequencing
  input wire logic soft_break_trap_i,
  input wire logic instr_end_i,
  input wire logic flag_set_i,
  input wire logic flag_clr_i,
  input wire logic oscillator_halt_op_i,
  // to core and clock tree
  output svc_t svc_o,
  output logic irq_disable_o,
  output logic phi_en_o,
  output logic osc_run_o
);
  typedef enum logic [2:0] {CLK_RUN = 3'b001, CLK_STOP = 3'b010, CLK_WAKE = 3'b100} clk_state_t;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] pick_winner(input logic [NUM_SRC-1:0] eff);
    logic [4:0] res;
    res = 5'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (eff[i]) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction

  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    logic [15:0] v;
    v = (idx == IDX_BREAK) ? VEC_BREAK_LO : 16'(VEC_TOP_LO - VEC_STEP * 16'(idx));
    return v;
  endfunction
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] edge_sel_reg, req1_reg, req2_reg, ctrl1_reg, ctrl2_reg;
  logic brk_reg, rst_pend_reg, dis_reg, phi_reg, osc_run_reg;
  logic [7:0] div_reg;
  logic wr1_pend_reg, wr2_pend_reg;
  logic [7:0] wr_data_reg;
  clk_state_t clk_state_reg;
  svc_t svc_reg;
  logic [7:0] rd_reg;

  logic [NUM_EXT-1:0] ext_evt;
  logic [7:0] ev1, ev2, acc1, acc2;
  logic [NUM_SRC-1:0] eff;
  logic [4:0] win;
  logic accept;

  irq_edge_detect #(.WIDTH(NUM_EXT)) u_edge (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .pin_i({ext_irq_in_f_i, ext_irq_in_e_i, ext_irq_in_d_i,
            ext_irq_in_c_i, ext_irq_in_b_i, ext_irq_in_a_i}),
    .rise_sel_i(edge_sel_reg[NUM_EXT-1:0]),
    .evt_o(ext_evt)
  );

  assign ev1 = {timer2_irq_i, timer1_uflow_i, timer_y_irq_i, timer_x_irq_i,
                serial_tx_irq_i, serial_rx_irq_i, ext_evt[1], ext_evt[0]};
  assign ev2 = {2'b00, ext_evt[5:2], counter_pin_b_irq_i, counter_pin_a_irq_i};
  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  // order never moves; software only masks what competes
  always_comb begin
    eff = {brk_reg, {req2_reg[5:0], req1_reg} & {ctrl2_reg[5:0], ctrl1_reg}
           & {14{~dis_reg}}};
    eff[IDX_SER_RX] = eff[IDX_SER_RX] & serial_sel_i;
    eff[IDX_SER_TX] = eff[IDX_SER_TX] & serial_sel_i;
  end

  assign win = pick_winner(eff);
  // reset is served at the first phi slot, no instruction boundary needed
  assign accept = phi_reg && (rst_pend_reg || (win[4] && instr_end_i));

  always_comb begin
    acc1 = 8'h00;
    acc2 = 8'h00;
    if (accept && !rst_pend_reg && win[3:0] != IDX_BREAK) begin
      if (win[3:0] < 4'h8) begin
        acc1[win[2:0]] = 1'b1;
      end else begin
        acc2[win[2:0]] = 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      edge_sel_reg <= REG_RST_VAL;
      ctrl1_reg <= REG_RST_VAL;
      ctrl2_reg <= REG_RST_VAL;
      wr1_pend_reg <= 1'b0;
      wr2_pend_reg <= 1'b0;
      wr_data_reg <= REG_RST_VAL;
    end else begin
      wr1_pend_reg <= sfr_i.we && sfr_i.addr == ADDR_REQ1;
      wr2_pend_reg <= sfr_i.we && sfr_i.addr == ADDR_REQ2;
      wr_data_reg <= sfr_i.wdata;
      if (sfr_i.we && sfr_i.addr == ADDR_EDGE_SEL) begin
        edge_sel_reg <= sfr_i.wdata & REQ2_USED_MASK;
      end
      if (sfr_i.we && sfr_i.addr == ADDR_CTRL1) begin
        ctrl1_reg <= sfr_i.wdata;
      end
      if (sfr_i.we && sfr_i.addr == ADDR_CTRL2) begin
        ctrl2_reg <= sfr_i.wdata & REQ2_USED_MASK;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rd_reg <= REG_RST_VAL;
    end else begin
      unique case (sfr_i.addr)
        ADDR_EDGE_SEL: rd_reg <= edge_sel_reg;
        ADDR_REQ1: rd_reg <= req1_reg;
        ADDR_REQ2: rd_reg <= req2_reg;
        ADDR_CTRL1: rd_reg <= ctrl1_reg;
        ADDR_CTRL2: rd_reg <= ctrl2_reg;
        default: rd_reg <= 8'h00;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // request flags
  // ----------------------------------------------------------------
  // written zeros clear, ones keep; a same-cycle event still wins
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      req1_reg <= REG_RST_VAL;
      req2_reg <= REG_RST_VAL;
      brk_reg <= 1'b0;
    end else begin
      req1_reg <= (req1_reg & ~acc1 & (wr1_pend_reg ? wr_data_reg : 8'hFF)) | ev1;
      req2_reg <= ((req2_reg & ~acc2 & (wr2_pend_reg ? wr_data_reg : 8'hFF)) | ev2)
                  & REQ2_USED_MASK;
      brk_reg <= (brk_reg & ~(accept && !rst_pend_reg && win[3:0] == IDX_BREAK))
                 | soft_break_trap_i;
    end
  end
  // ----------------------------------------------------------------
  // disable flag and service hand-off
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      dis_reg <= 1'b1;
    end else if (accept || flag_set_i) begin
      dis_reg <= 1'b1;
    end else if (flag_clr_i) begin
      dis_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rst_pend_reg <= 1'b1;
      svc_reg <= '0;
    end else begin
      svc_reg.start <= accept;
      if (accept) begin
        rst_pend_reg <= 1'b0;
        svc_reg.vec_lo <= rst_pend_reg ? VEC_RESET_LO : vec_of(win[3:0]);
        svc_reg.vec_hi <= 16'((rst_pend_reg ? VEC_RESET_LO : vec_of(win[3:0])) + 16'h0001);
      end
    end
  end
  // ----------------------------------------------------------------
  // oscillator and phi enable
  // ----------------------------------------------------------------
  // phi halts low: no enable pulses leave while stopped or waking
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      clk_state_reg <= CLK_RUN;
    end else begin
      unique case (clk_state_reg)
        CLK_RUN: if (oscillator_halt_op_i) clk_state_reg <= CLK_STOP;
        CLK_STOP: if (|ext_evt) clk_state_reg <= CLK_WAKE;
        CLK_WAKE: if (timer1_uflow_i) clk_state_reg <= CLK_RUN;
        default: clk_state_reg <= CLK_RUN;
      endcase
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      osc_run_reg <= 1'b1;
    end else begin
      osc_run_reg <= !((clk_state_reg == CLK_RUN && oscillator_halt_op_i)
                       || (clk_state_reg == CLK_STOP && !(|ext_evt)));
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i || clk_state_reg != CLK_RUN || oscillator_halt_op_i) begin
      div_reg <= 8'h00;
      phi_reg <= 1'b0;
    end else begin
      div_reg <= (div_reg == 8'(PHI_DIV - 8'h01)) ? 8'h00 : 8'(div_reg + 8'h01);
      phi_reg <= div_reg == 8'(PHI_DIV - 8'h01);
    end
  end

  assign svc_o = svc_reg;
  assign rd_data_o = rd_reg;
  assign irq_disable_o = dis_reg;
  assign phi_en_o = phi_reg;
  assign osc_run_o = osc_run_reg;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  sequence s_accept_idx(logic [3:0] idx);
    accept && !rst_pend_reg && win[3:0] == idx;
  endsequence
  property p_first_reset_vec;
    $fell(rst_pend_reg) |-> svc_reg.start && svc_reg.vec_lo == 16'hFFFC;
  endproperty
  a_first_reset_vec: assert property (p_first_reset_vec) else $error("reset vector wrong");
  property p_pair;
    svc_reg.start |-> svc_reg.vec_hi == 16'(svc_reg.vec_lo + 16'h0001);
  endproperty
  a_pair: assert property (p_pair) else $error("vector pair not adjacent");
  property p_rx_vec;
    s_accept_idx(IDX_SER_RX) |=> svc_reg.vec_lo == 16'hFFF6;
  endproperty
  a_rx_vec: assert property (p_rx_vec) else $error("receive vector wrong");
  property p_tx_vec;
    s_accept_idx(IDX_SER_TX) |=> svc_reg.vec_lo == 16'hFFF4;
  endproperty
  a_tx_vec: assert property (p_tx_vec) else $error("transmit vector wrong");
  property p_t1_vec;
    s_accept_idx(IDX_TIMER1) |=> svc_reg.vec_lo == 16'hFFEE;
  endproperty
  a_t1_vec: assert property (p_t1_vec) else $error("timer 1 vector wrong");
  property p_brk_vec;
    s_accept_idx(IDX_BREAK) |=> svc_reg.vec_lo == 16'hFFDC && svc_reg.start;
  endproperty
  a_brk_vec: assert property (p_brk_vec) else $error("break vector wrong");
  property p_serial_gate;
    !serial_sel_i |-> !(accept && !rst_pend_reg
                        && (win[3:0] == IDX_SER_RX || win[3:0] == IDX_SER_TX));
  endproperty
  a_serial_gate: assert property (p_serial_gate) else $error("serial taken unselected");
  property p_highest;
    accept && !rst_pend_reg |-> (eff & ((15'h0001 << win[3:0]) - 15'h0001)) == 15'h0000;
  endproperty
  a_highest: assert property (p_highest) else $error("lower priority won");
  property p_boundary;
    svc_reg.start && !$past(rst_pend_reg) |-> $past(instr_end_i) && $past(phi_reg);
  endproperty
  a_boundary: assert property (p_boundary) else $error("service off boundary");
  property p_t1_cleared;
    accept && !rst_pend_reg && win[3:0] == IDX_TIMER1 && !timer1_uflow_i |=> !req1_reg[6];
  endproperty
  a_t1_cleared: assert property (p_t1_cleared) else $error("flag not cleared");
  // a timer y event in the clear cycle legitimately keeps the flag
  property p_write_late;
    sfr_i.we && sfr_i.addr == ADDR_REQ1 && sfr_i.wdata == 8'h00 && req1_reg[5] && !accept
      |=> req1_reg[5] ##1 (!req1_reg[5] || $past(timer_y_irq_i));
  endproperty
  a_write_late: assert property (p_write_late) else $error("request write too early");
  property p_stop_phi;
    clk_state_reg != CLK_RUN |-> ##1 !phi_reg;
  endproperty
  a_stop_phi: assert property (p_stop_phi) else $error("phi ran while stopped");
  property p_wake_end;
    clk_state_reg == CLK_WAKE && timer1_uflow_i |=> clk_state_reg == CLK_RUN;
  endproperty
  a_wake_end: assert property (p_wake_end) else $error("wait not ended by underflow");
  property p_brk_nmi;
    brk_reg && eff[13:0] == 14'h0000 && instr_end_i && phi_reg && !rst_pend_reg
      |=> svc_reg.start && svc_reg.vec_lo == 16'hFFDC;
  endproperty
  a_brk_nmi: assert property (p_brk_nmi) else $error("break blocked");
  property p_reset_values;
    $fell(srst_i) |-> dis_reg && req1_reg == 8'h00 && ctrl2_reg == 8'h00
                      && edge_sel_reg == 8'h00;
  endproperty
  a_reset_values: assert property (disable iff (1'b0) p_reset_values)
    else $error("reset values wrong");
endmodule // vectored_fixed_priority_irq
`default_nettype wire
